// ==== verilog/uip_pkg.sv ====
// Register map, field positions, codes and state record of the interrupt and format block.
package uip_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFS_INT_SOURCE    = 8'h00;
    localparam logic [7:0] OFS_LINE_FORMAT   = 8'h04;
    localparam logic [7:0] OFS_FEATURE       = 8'h08;
    localparam logic [7:0] OFS_EVENT_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_EVENT_MASK    = 8'h10;

    // Interrupt source codes for bits five down to zero.
    localparam logic [5:0] CODE_LINE_STATUS  = 6'h06;
    localparam logic [5:0] CODE_RX_DATA      = 6'h04;
    localparam logic [5:0] CODE_RX_TIMEOUT   = 6'h0C;
    localparam logic [5:0] CODE_THR_EMPTY    = 6'h02;
    localparam logic [5:0] CODE_MODEM        = 6'h00;
    localparam logic [5:0] CODE_XOFF_SPECIAL = 6'h10;
    localparam logic [5:0] CODE_FLOW_CHANGE  = 6'h20;
    localparam logic [5:0] CODE_NONE         = 6'h01;

    // Field positions in the line format control register.
    localparam int LF_DIVISOR_BIT = 7;
    localparam int LF_BREAK_BIT   = 6;
    localparam int LF_STICK_BIT   = 5;
    localparam int LF_EVEN_BIT    = 4;
    localparam int LF_PARITY_BIT  = 3;
    localparam int LF_STOP_BIT    = 2;

    // Field positions in the feature control register.
    localparam int FT_FIFO_BIT     = 0;
    localparam int FT_ENHANCED_BIT = 4;

    // Reset values.
    localparam logic [7:0] LINE_FORMAT_RESET = 8'h00;
    localparam logic [7:0] FEATURE_RESET     = 8'h00;
    localparam logic [6:0] EVENT_RESET       = 7'h00;

    // Stop length in half bit times.
    localparam logic [2:0] STOP_HALVES_ONE       = 3'h2;
    localparam logic [2:0] STOP_HALVES_ONE_HALF  = 3'h3;
    localparam logic [2:0] STOP_HALVES_TWO       = 3'h4;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Bus channel states.
    typedef enum logic [0:0] {
        CH_IDLE = 1'b0,
        CH_RESP = 1'b1
    } uip_chan_type;

    // Pending interrupt sources from the rest of the channel.
    typedef struct packed {
        logic line_status;
        logic rx_data;
        logic rx_timeout;
        logic thr_empty;
        logic modem;
        logic xoff_detect;
        logic xon_detect;
        logic flow_change;
    } uip_sources_type;

    // Line format as decoded for transmitter and receiver.
    typedef struct packed {
        logic [3:0] word_bits;
        logic [2:0] stop_halves;
        logic       parity_on;
        logic       parity_odd;
        logic       parity_forced;
        logic       parity_level;
        logic       divisor_access;
    } uip_format_type;

    // Complete state of the block.
    typedef struct packed {
        uip_chan_type   wr_state;
        logic           awready;
        logic           wready;
        logic           aw_got;
        logic [7:0]     awaddr;
        logic           w_got;
        logic [7:0]     wdata;
        logic           wstrb0;
        logic           bvalid;
        logic [1:0]     bresp;
        uip_chan_type   rd_state;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        logic [7:0]     line_format;
        logic [7:0]     feature;
        logic           xoff_hold;
        logic [6:0]     ev_status;
        logic [6:0]     ev_mask;
        logic           irq;
        logic           tx_line;
        uip_format_type format;
    } uip_state_type;

endpackage

// ==== verilog/uip_top.sv ====
// Interrupt priority, line format control and AXI4-Lite register slave for one UART channel.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE1 - Status read returns highest pending code.
// RULE2 - Lower levels hidden until higher one serviced.
// RULE3 - Line status is level one, code 000110.
// RULE4 - Level two: data 000100, timeout 001100.
// RULE5 - Transmit holding empty level three, 000010.
// RULE6 - Modem status level four, code 000000.
// RULE7 - CTS/RTS change level six, code 100000.
// RULE8 - Bit zero low when pending, reset high.
// RULE9 - Bits seven, six follow FIFO enable.
// RULE10 - Bits five, four need enhanced bit four.
// RULE11 - Xoff sets bit four until Xon.
// RULE12 - Format bit seven selects divisor access.
// RULE13 - Format bit six forces transmit low.
// RULE14 - Bits five to three select parity.
// RULE15 - Bit two picks one, 1.5, two stops.
// RULE16 - Bits one, zero pick 5 to 8.
// RULE17 - Pattern 001 odd, 101 forced one.
// RULE18 - Line format clears to zero on reset.
module uip_top (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire uip_pkg::uip_sources_type sources,
    input  wire logic                    tx_serial,
    output logic                         tx_line,
    output uip_pkg::uip_format_type      format,
    output logic                         irq
);

    // Registered state and its next value.
    uip_pkg::uip_state_type st_reg;
    uip_pkg::uip_state_type st_next;

    // Current priority code for bits five down to zero.
    logic [5:0] code;
    // Full status byte as it would read now.
    logic [7:0] isr_value;
    // Enhanced features enabled.
    logic       enhanced;
    // Events raised this cycle, one per status bit.
    logic [6:0] ev_raise;
    // Write and read handshake conditions.
    logic       do_write;
    logic       do_read;

    // Priority encoder: the first pending level wins and hides all below it.
    always_comb begin
        enhanced = st_reg.feature[uip_pkg::FT_ENHANCED_BIT];
        if (sources.line_status) begin
            code = uip_pkg::CODE_LINE_STATUS; // RULE3 RULE2
        end else if (sources.rx_timeout) begin
            code = uip_pkg::CODE_RX_TIMEOUT; // RULE4
        end else if (sources.rx_data) begin
            code = uip_pkg::CODE_RX_DATA; // RULE4
        end else if (sources.thr_empty) begin
            code = uip_pkg::CODE_THR_EMPTY; // RULE5
        end else if (sources.modem) begin
            code = uip_pkg::CODE_MODEM; // RULE6
        end else if (enhanced && st_reg.xoff_hold) begin
            code = uip_pkg::CODE_XOFF_SPECIAL; // RULE10 RULE11
        end else if (enhanced && sources.flow_change) begin
            code = uip_pkg::CODE_FLOW_CHANGE; // RULE7 RULE10
        end else begin
            code = uip_pkg::CODE_NONE; // RULE8
        end
        // Both top bits mirror the FIFO enable.
        isr_value = {{2{st_reg.feature[uip_pkg::FT_FIFO_BIT]}}, code}; // RULE9 RULE1
    end

    // Events feeding the sticky status: each pending level sets its bit, the Xoff hold and flow change bits only when enhanced.
    always_comb begin
        ev_raise = {sources.flow_change & enhanced,
                    st_reg.xoff_hold & enhanced,
                    sources.modem,
                    sources.thr_empty,
                    sources.rx_timeout,
                    sources.rx_data,
                    sources.line_status};
    end

    // Next-state logic for bus, registers and outputs.
    always_comb begin
        st_next  = st_reg;
        do_write = 1'b0;
        do_read  = 1'b0;

        // Capture write address when offered.
        if (st_reg.awready && s_axi_awvalid) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        // Capture write data when offered, in either order.
        if (st_reg.wready && s_axi_wvalid) begin
            st_next.w_got  = 1'b1;
            st_next.wdata  = s_axi_wdata[7:0];
            st_next.wstrb0 = s_axi_wstrb[0];
        end

        // Write channel machine.
        case (st_reg.wr_state)
            uip_pkg::CH_IDLE: begin
                // Both halves present: perform the write and answer.
                if (st_reg.aw_got && st_reg.w_got) begin
                    do_write        = 1'b1;
                    st_next.aw_got  = 1'b0;
                    st_next.w_got   = 1'b0;
                    st_next.bvalid  = 1'b1;
                    st_next.wr_state = uip_pkg::CH_RESP;
                end
            end
            uip_pkg::CH_RESP: begin
                // Hold the response until the master accepts it.
                if (s_axi_bready) begin
                    st_next.bvalid   = 1'b0;
                    st_next.wr_state = uip_pkg::CH_IDLE;
                end
            end
            default: begin
                st_next.wr_state = uip_pkg::CH_IDLE;
            end
        endcase
        st_next.awready = ~st_next.aw_got & (st_next.wr_state == uip_pkg::CH_IDLE) & ~do_write;
        st_next.wready  = ~st_next.w_got & (st_next.wr_state == uip_pkg::CH_IDLE) & ~do_write;

        // Sticky events: a hardware set wins over a software clear.
        st_next.ev_status = st_reg.ev_status | ev_raise;

        // Register writes; only the low byte lane carries data.
        if (do_write) begin
            st_next.bresp = uip_pkg::RESP_OKAY;
            case (st_reg.awaddr)
                uip_pkg::OFS_INT_SOURCE: begin
                    // Read-only status; writes are ignored.
                end
                uip_pkg::OFS_LINE_FORMAT: begin
                    if (st_reg.wstrb0) begin
                        st_next.line_format = st_reg.wdata;
                    end
                end
                uip_pkg::OFS_FEATURE: begin
                    if (st_reg.wstrb0) begin
                        st_next.feature = st_reg.wdata;
                    end
                end
                uip_pkg::OFS_EVENT_STATUS: begin
                    // Write one to clear, then re-apply this cycle's events.
                    if (st_reg.wstrb0) begin
                        st_next.ev_status = (st_reg.ev_status & ~st_reg.wdata[6:0]) | ev_raise;
                    end
                end
                uip_pkg::OFS_EVENT_MASK: begin
                    if (st_reg.wstrb0) begin
                        st_next.ev_mask = st_reg.wdata[6:0];
                    end
                end
                default: begin
                    st_next.bresp = uip_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read channel machine.
        case (st_reg.rd_state)
            uip_pkg::CH_IDLE: begin
                if (st_reg.arready && s_axi_arvalid) begin
                    do_read          = 1'b1;
                    st_next.arready  = 1'b0;
                    st_next.rvalid   = 1'b1;
                    st_next.rresp    = uip_pkg::RESP_OKAY;
                    st_next.rd_state = uip_pkg::CH_RESP;
                end
            end
            uip_pkg::CH_RESP: begin
                if (s_axi_rready) begin
                    st_next.rvalid   = 1'b0;
                    st_next.arready  = 1'b1;
                    st_next.rd_state = uip_pkg::CH_IDLE;
                end
            end
            default: begin
                st_next.rd_state = uip_pkg::CH_IDLE;
            end
        endcase

        // Read data: the status byte is snapshotted at the moment of the read.
        if (do_read) begin
            case (s_axi_araddr)
                uip_pkg::OFS_INT_SOURCE: begin
                    st_next.rdata = {24'h000000, isr_value}; // RULE1 RULE2
                end
                uip_pkg::OFS_LINE_FORMAT: begin
                    st_next.rdata = {24'h000000, st_reg.line_format};
                end
                uip_pkg::OFS_FEATURE: begin
                    st_next.rdata = {24'h000000, st_reg.feature};
                end
                uip_pkg::OFS_EVENT_STATUS: begin
                    st_next.rdata = {25'h0000000, st_reg.ev_status};
                end
                uip_pkg::OFS_EVENT_MASK: begin
                    st_next.rdata = {25'h0000000, st_reg.ev_mask};
                end
                default: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = uip_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Xoff or special character sets the hold; only Xon releases it, set wins.
        if (sources.xoff_detect) begin
            st_next.xoff_hold = 1'b1; // RULE11
        end else if (sources.xon_detect) begin
            st_next.xoff_hold = 1'b0; // RULE11
        end

        // Interrupt line is high while an unmasked sticky bit is set.
        st_next.irq = |(st_next.ev_status & st_next.ev_mask);

        // Break forces the line low; otherwise the transmitter drives it.
        st_next.tx_line = st_next.line_format[uip_pkg::LF_BREAK_BIT] ? 1'b0 : tx_serial; // RULE13

        // Word length from the two low bits.
        st_next.format.word_bits = 4'h5 + {2'b00, st_next.line_format[1:0]}; // RULE16

        // Stop length depends on word length when the stop bit is set.
        if (!st_next.line_format[uip_pkg::LF_STOP_BIT]) begin
            st_next.format.stop_halves = uip_pkg::STOP_HALVES_ONE; // RULE15
        end else if (st_next.line_format[1:0] == 2'h0) begin
            st_next.format.stop_halves = uip_pkg::STOP_HALVES_ONE_HALF; // RULE15
        end else begin
            st_next.format.stop_halves = uip_pkg::STOP_HALVES_TWO; // RULE15
        end

        // Parity: 001 odd, 011 even, 101 forced one, 111 forced zero.
        st_next.format.parity_on     = st_next.line_format[uip_pkg::LF_PARITY_BIT]; // RULE14
        st_next.format.parity_odd    = ~st_next.line_format[uip_pkg::LF_EVEN_BIT]; // RULE14 RULE17
        st_next.format.parity_forced = st_next.line_format[uip_pkg::LF_STICK_BIT]; // RULE17
        st_next.format.parity_level  = ~st_next.line_format[uip_pkg::LF_EVEN_BIT]; // RULE14 RULE17

        // Divisor register access select.
        st_next.format.divisor_access = st_next.line_format[uip_pkg::LF_DIVISOR_BIT]; // RULE12
    end

    // State register with synchronous active-low reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Clearing the record also leaves both channel machines idle.
            st_reg <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.line_format <= uip_pkg::LINE_FORMAT_RESET; // RULE18
            st_reg.feature <= uip_pkg::FEATURE_RESET;
            st_reg.ev_status <= uip_pkg::EVENT_RESET;
            st_reg.ev_mask <= uip_pkg::EVENT_RESET;
            st_reg.tx_line <= 1'b1;
            st_reg.format.word_bits <= 4'h5;
            st_reg.format.stop_halves <= uip_pkg::STOP_HALVES_ONE;
            st_reg.format.parity_odd <= 1'b1;
            st_reg.format.parity_level <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flip-flops.
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign tx_line       = st_reg.tx_line;
    assign format        = st_reg.format;
    assign irq           = st_reg.irq;

endmodule
`default_nettype wire

// ==== verif/uip_props.sv ====
// Checker of bus timing, status codes and line format seen at the block's ports.
`timescale 1ns/1ns
`default_nettype none
module uip_props (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic                     s_axi_bvalid,
    input wire logic [7:0]               s_axi_araddr,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [31:0]              s_axi_rdata,
    input wire logic                     s_axi_rvalid,
    input wire uip_pkg::uip_sources_type sources,
    input wire logic                     tx_serial,
    input wire logic                     tx_line,
    input wire uip_pkg::uip_format_type  format
);
    // All checks use the bus clock and rest while reset is low.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // High on the edge that takes a read of the status register.
    wire st_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == uip_pkg::OFS_INT_SOURCE);
    // Read data follows on the edge after the address is taken.
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    // A write answer comes within three edges of taking address and data.
    property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    // Line status outranks every other source.
    property p_top; st_rd && sources.line_status |=> s_axi_rdata[5:0] == uip_pkg::CODE_LINE_STATUS; endproperty
    a_top: assert property (p_top) else $error("line status code wrong");
    // Without line status a receive timeout gives its own code.
    property p_tmo; st_rd && !sources.line_status && sources.rx_timeout |=> s_axi_rdata[5:0] == 6'h0C; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout code wrong");
    // A pending data, holding-empty or modem source pulls the pending flag low.
    property p_pend; st_rd && (sources.rx_data || sources.thr_empty || sources.modem) |=> !s_axi_rdata[0]; endproperty
    a_pend: assert property (p_pend) else $error("pending flag wrong");
    // A high transmit pin can only come from high serial data.
    property p_brk; tx_line |-> $past(tx_serial); endproperty
    a_brk: assert property (p_brk) else $error("transmit pin high without data");
    // One and a half stop bits exist only with five data bits.
    property p_s15; format.stop_halves == uip_pkg::STOP_HALVES_ONE_HALF |-> format.word_bits == 4'h5; endproperty
    a_s15: assert property (p_s15) else $error("half stop with wrong length");
    // Two stop bits never come with five data bits.
    property p_s2; format.stop_halves == uip_pkg::STOP_HALVES_TWO |-> format.word_bits != 4'h5; endproperty
    a_s2: assert property (p_s2) else $error("two stops with five bits");
    // Main scenarios reached.
    c_top: cover property (st_rd && sources.line_status);
    c_wr: cover property (s_axi_bvalid);
    c_brk: cover property ($fell(tx_line));
endmodule
bind uip_top uip_props props_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .sources(sources), .tx_serial(tx_serial), .tx_line(tx_line), .format(format));
`default_nettype wire

// ==== verif/uip_host.sv ====
// Host model issuing register reads and writes on the AXI4-Lite bus.
`timescale 1ns/1ns
`default_nettype none
module uip_host (
    input  wire logic        aclk,
    output var  logic [7:0]  awaddr,
    output var  logic        awvalid,
    input  wire logic        awready,
    output var  logic [31:0] wdata,
    output var  logic [3:0]  wstrb,
    output var  logic        wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output var  logic        bready,
    output var  logic [7:0]  araddr,
    output var  logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output var  logic        rready
);
    // The bus is idle from time zero.
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end
    // Write: address and data offered together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic dd;
        @(posedge aclk);
        {ad, dd} = 2'b00;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'b111;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            ad = ad || awready;
            dd = dd || wready;
        end
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    // Read: address held until taken, data taken when valid.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/uip_tb_top.sv ====
// Self-checking testbench of the interrupt priority and line format block.
`timescale 1ns/1ns
`default_nettype none
module uip_tb_top;
    logic                     aclk, aresetn, tx_serial, tx_line, irq; // Clock, reset, transmit, interrupt.
    logic [7:0]               awaddr, araddr; // Bus addresses.
    logic [31:0]              wdata, rdata; // Bus data.
    logic [3:0]               wstrb; // Byte strobes.
    logic [1:0]               bresp, rresp; // Bus answers.
    logic                     awvalid, awready, wvalid, wready, bvalid, bready; // Write handshakes.
    logic                     arvalid, arready, rvalid, rready; // Read handshakes.
    uip_pkg::uip_sources_type sources; // Pending sources.
    uip_pkg::uip_format_type  fmt_out; // Decoded format.
    int                       errors, num_checks; // Verdict counters.
    localparam logic [7:0]    A_SRC = uip_pkg::OFS_INT_SOURCE; // Offsets used most often.
    localparam logic [7:0]    A_FMT = uip_pkg::OFS_LINE_FORMAT;
    localparam logic [7:0]    A_EVS = uip_pkg::OFS_EVENT_STATUS;
    // Clock at 125 MHz.
    initial aclk = 1'b0;
    always #4 aclk = ~aclk;
    uip_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sources(sources),
        .tx_serial(tx_serial), .tx_line(tx_line), .format(fmt_out), .irq(irq));
    uip_host host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Reads a register and compares it, or writes one ignoring the answer.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        host_u.rd(a, d, r);
        check(d, e);
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host_u.wr(a, d, r);
    endtask
    // Compares the decoded format with the control byte.
    task automatic check_fmt(input logic [7:0] l);
        check({fmt_out.word_bits, fmt_out.stop_halves, fmt_out.parity_on, fmt_out.parity_forced,
            fmt_out.divisor_access}, {4'h5 + 4'(l[1:0]), !l[2] ? uip_pkg::STOP_HALVES_ONE :
            (l[1:0] == 2'h0 ? uip_pkg::STOP_HALVES_ONE_HALF : uip_pkg::STOP_HALVES_TWO), l[3], l[5], l[7]});
        check(32'(l[5] ? fmt_out.parity_level : fmt_out.parity_odd), 32'(!l[4]));
    endtask
    // Every word length and stop choice, each parity pattern, then divisor access.
    task automatic t_format();
        logic [2:0] pat [8] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7, 3'h0, 3'h1, 3'h3};
        logic [7:0] l;
        for (int i = 0; i < 8; i++) begin
            l = {2'b00, pat[i], 3'(i)};
            wrc(A_FMT, {24'h0, l});
            rdc(A_FMT, {24'h0, l});
            check_fmt(l);
        end
        wrc(A_FMT, 32'h83);
        check_fmt(8'h83);
    endtask
    // Data follows the pin, break forces it low until cleared.
    task automatic t_break();
        tx_serial <= 1'b0;
        wrc(A_FMT, 32'h00);
        check(32'(tx_line), 32'h0);
        tx_serial <= 1'b1;
        wrc(A_FMT, 32'h40);
        repeat (2) @(posedge aclk);
        check(32'(tx_line), 32'h0);
        wrc(A_FMT, 32'h00);
        repeat (2) @(posedge aclk);
        check(32'(tx_line), 32'h1);
    endtask
    // Sources removed from the top down; each read shows the highest remaining level.
    task automatic t_prio();
        logic [7:0] src [7] = '{8'hF9, 8'h79, 8'h59, 8'h19, 8'h09, 8'h01, 8'h00};
        logic [7:0] want [7] = '{8'hC6, 8'hCC, 8'hC4, 8'hC2, 8'hC0, 8'hE0, 8'hC1};
        wrc(uip_pkg::OFS_FEATURE, 32'h11);
        for (int i = 0; i < 7; i++) begin
            sources <= src[i];
            rdc(A_SRC, {24'h0, want[i]});
        end
        sources <= 8'h04;
        @(posedge aclk);
        sources <= 8'h10;
        rdc(A_SRC, 32'hC2);
        sources <= 8'h00;
        rdc(A_SRC, 32'hD0);
        sources <= 8'h02;
        @(posedge aclk);
        sources <= 8'h01;
        wrc(uip_pkg::OFS_FEATURE, 32'h01);
        rdc(A_SRC, 32'hC1);
        wrc(uip_pkg::OFS_FEATURE, 32'h00);
        rdc(A_SRC, 32'h01);
        sources <= 8'h00;
    endtask
    // Sticky event raised, masked, cleared; then bad addresses and a read-only write.
    task automatic t_irq_bad();
        logic [31:0] d;
        logic [1:0]  r;
        wrc(A_EVS, 32'h7F);
        wrc(uip_pkg::OFS_EVENT_MASK, 32'h01);
        sources <= 8'h80;
        repeat (3) @(posedge aclk);
        check(32'(irq), 32'h1);
        sources <= 8'h00;
        rdc(A_EVS, 32'h01);
        wrc(uip_pkg::OFS_EVENT_MASK, 32'h00);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0);
        wrc(A_EVS, 32'h01);
        rdc(A_EVS, 32'h00);
        host_u.rd(8'h40, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(uip_pkg::RESP_SLVERR));
        host_u.wr(8'h44, 32'hFF, r);
        check(32'(r), 32'(uip_pkg::RESP_SLVERR));
        wrc(A_SRC, 32'hFF);
        rdc(A_SRC, 32'h01);
    endtask
    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence: reset values first, then each scenario.
    initial begin
        {errors, num_checks} = '0;
        {aresetn, sources, tx_serial} = {1'b0, 8'h00, 1'b1};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(A_FMT, 32'h0);
        rdc(A_SRC, 32'h01);
        check_fmt(8'h00);
        t_format();
        t_break();
        t_prio();
        t_irq_bad();
        give_verdict();
    end
    // Cuts a hang short.
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
